//--- hopp_top.sv
`default_nettype none
// ----------------------------------------
// home offset and position preset
// ----------------------------------------
module hopp_top #(
    parameter int GEAR_W = hopp_pkg::GEAR_W
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic home_offset_wr,
    input wire logic [31:0] home_offset_wdata,
    output logic [31:0] home_offset_rdata,
    input wire hopp_pkg::hopp_trig_t trig,
    input wire logic home_detected,
    input wire logic full_closed,
    input wire logic absolute_system,
    input wire logic new_behaviour,
    input wire logic [7:0] direction_polarity,
    input wire logic [GEAR_W-1:0] gear_reverse,
    input wire logic [23:0] scale_high,
    input wire logic [23:0] scale_low,
    input wire logic [31:0] encoder_position,
    input wire logic [31:0] demand_step,
    output hopp_pkg::hopp_pos_t pos,
    output logic [23:0] abs_scale_offset_high,
    output logic [23:0] abs_scale_offset_low,
    output logic counter_overflow_trip
);
    logic [31:0] home_offset_reg, home_offset_next;
    logic [31:0] active_offset_reg, active_offset_next;
    hopp_pkg::hopp_pos_t pos_reg, pos_next;
    logic [23:0] ofs_h_reg, ofs_h_next, ofs_l_reg, ofs_l_next;
    logic [31:0] enc_zero_reg, enc_zero_next;
    logic trip_reg, trip_next;
    logic apply;
    hopp_pkg::hopp_init_t kind;
    logic [31:0] int_val, scaled_val;
    logic ovf;
    logic [31:0] actual_int;
    logic [31:0] user_act;
    logic home_load;

    hopp_trig_decode u_trig (
        .ref_clk(ref_clk),
        .srst(srst),
        .trig(trig),
        .apply(apply),
        .kind(kind)
    );

    hopp_scale_calc #(.GEAR_W(GEAR_W)) u_calc (
        .scale_high(scale_high),
        .scale_low(scale_low),
        .offset_high(ofs_h_reg),
        .offset_low(ofs_l_reg),
        .gear_reverse(gear_reverse),
        .reversed(direction_polarity == hopp_pkg::POLARITY_REVERSED),
        .internal_value(int_val),
        .scaled_value(scaled_val),
        .overflow(ovf)
    );

    // ----------------------------------------
    // offset register and latched copy
    // ----------------------------------------
    // writes land at once; the copy the arithmetic sees changes only on triggers
    always_comb begin
        home_offset_next = home_offset_reg;
        if (home_offset_wr) begin
            home_offset_next = home_offset_wdata;
        end
        active_offset_next = active_offset_reg;
        if (apply) begin
            active_offset_next = home_offset_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            home_offset_reg <= hopp_pkg::HOME_OFFSET_RESET;
            active_offset_reg <= hopp_pkg::HOME_OFFSET_RESET;
        end else begin
            home_offset_reg <= home_offset_next;
            active_offset_reg <= active_offset_next;
        end
    end

    // ----------------------------------------
    // coordinate sources
    // ----------------------------------------
    // encoder path is relative to a zero captured at home presets with home_load set (cleared by other presets in old absolute mode); the preset edge
    // already counts from the new zero, so demand and actual agree at once
    always_comb begin
        home_load = home_detected || !absolute_system || new_behaviour;
        enc_zero_next = enc_zero_reg;
        if (kind == hopp_pkg::HOPP_INIT_HOME && home_load) begin
            enc_zero_next = encoder_position;
        end else if (kind == hopp_pkg::HOPP_INIT_OTHER && absolute_system && !new_behaviour) begin
            enc_zero_next = '0;
        end
        if (full_closed && absolute_system) begin
            actual_int = int_val;
        end else begin
            actual_int = encoder_position - enc_zero_next;
        end
        // the offset applied at this edge is already the one in use
        if (full_closed && absolute_system) begin
            user_act = scaled_val + active_offset_next;
        end else if (direction_polarity == hopp_pkg::POLARITY_REVERSED) begin
            user_act = active_offset_next - actual_int;
        end else begin
            user_act = actual_int + active_offset_next;
        end
    end

    // ----------------------------------------
    // preset and tracking
    // ----------------------------------------
    // every field moves in the same edge so a reader never sees a mix
    always_comb begin
        pos_next = pos_reg;
        ofs_h_next = ofs_h_reg;
        ofs_l_next = ofs_l_reg;
        trip_next = trip_reg;
        pos_next.internal_actual_position = actual_int;
        pos_next.user_actual_position = user_act;
        pos_next.internal_demand_position = pos_reg.internal_demand_position + demand_step;
        pos_next.user_demand_position = pos_reg.user_demand_position + demand_step;
        if (full_closed && ovf) begin
            trip_next = 1'b1;
        end
        unique case (kind)
            hopp_pkg::HOPP_INIT_HOME: begin
                // index position becomes the offset value
                if (home_load) begin
                    ofs_h_next = 24'(-scale_high);
                    ofs_l_next = 24'(-scale_low);
                end
                pos_next.internal_actual_position = '0;
                pos_next.internal_demand_position = '0;
                pos_next.user_demand_position = active_offset_next;
                pos_next.user_actual_position = active_offset_next;
            end
            hopp_pkg::HOPP_INIT_OTHER: begin
                // user values take the gear and polarity path, as tracking does next cycle
                pos_next.internal_demand_position = actual_int;
                pos_next.user_demand_position = user_act;
                pos_next.user_actual_position = user_act;
            end
            hopp_pkg::HOPP_INIT_NONE: begin
            end
        endcase
        // trip is sticky until a reinitialisation clears it
        if (apply && !(full_closed && ovf)) begin
            trip_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pos_reg <= '0;
            ofs_h_reg <= '0;
            ofs_l_reg <= '0;
            enc_zero_reg <= '0;
            trip_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            ofs_h_reg <= ofs_h_next;
            ofs_l_reg <= ofs_l_next;
            enc_zero_reg <= enc_zero_next;
            trip_reg <= trip_next;
        end
    end

    assign home_offset_rdata = home_offset_reg;
    assign pos = pos_reg;
    assign abs_scale_offset_high = ofs_h_reg;
    assign abs_scale_offset_low = ofs_l_reg;
    assign counter_overflow_trip = trip_reg;
endmodule
`default_nettype wire

//--- hopp_pkg.sv
// Functional notes
// - offset writes held until a trigger event
// - apply at power-up and Init-to-PreOP
// - apply when homing operation finishes
// - apply on absolute multi-turn clear
// - apply on command trip, tool ops, pins
// - home detect: internal zero, user equals offset
// - other init: demand=actual, user=actual+offset
// - after homing index reads as offset
// - incremental zero is power-on or home-offset
// - old absolute: encoder or scale zero
// - new absolute: zero is home minus offset
// - new full-closed: scale zero from offsets
// - 48-bit scale from halves, 32-bit objects
// - internal actual keeps low 32 bits
// - internal actual adds offsets, polarity-free
// - polarity 0: sum times gear plus offset
// - reversed polarity negates scaled sum
// - full-closed scaled overflow raises trip
// - homing loads offsets with negated halves
`default_nettype none
package hopp_pkg;
    localparam logic [15:0] HOME_OFFSET_INDEX = 16'h607C;
    localparam logic [31:0] HOME_OFFSET_RESET = 32'h0000_0000;
    localparam logic [7:0] POLARITY_REVERSED = 8'hE0;
    localparam int SCALE_HALF_W = 24;
    localparam int SCALE_W = 48;
    localparam int POS_W = 32;
    localparam int GEAR_W = 16;
    localparam logic [15:0] GEAR_RESET = 16'h0001;

    typedef enum logic [1:0] {
        HOPP_INIT_NONE,
        HOPP_INIT_HOME,
        HOPP_INIT_OTHER
    } hopp_init_t;

    typedef struct packed {
        logic [31:0] internal_actual_position;
        logic [31:0] internal_demand_position;
        logic [31:0] user_demand_position;
        logic [31:0] user_actual_position;
    } hopp_pos_t;

    typedef struct packed {
        logic power_up;
        logic init_to_preop;
        logic homing_done;
        logic multiturn_clear;
        logic command_error_trip;
        logic tool_op_done;
        logic pin_assign_changed;
    } hopp_trig_t;
endpackage
`default_nettype wire

//--- hopp_trig_decode.sv
`default_nettype none
// ----------------------------------------
// trigger collection and init classification
// ----------------------------------------
module hopp_trig_decode (
    input wire logic ref_clk,
    input wire logic srst,
    input wire hopp_pkg::hopp_trig_t trig,
    output logic apply,
    output hopp_pkg::hopp_init_t kind
);
    logic pwr_reg;
    logic pwr_next;

    // power-up counts as a trigger once, on the first cycle out of reset
    always_comb begin
        pwr_next = 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pwr_reg <= 1'b1;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // homing wins over any other event in the same cycle
    always_comb begin
        apply = pwr_reg | trig.power_up | trig.init_to_preop
              | trig.homing_done
              | trig.multiturn_clear
              | trig.command_error_trip | trig.tool_op_done
              | trig.pin_assign_changed;
        if (trig.homing_done) begin
            kind = hopp_pkg::HOPP_INIT_HOME;
        end else if (apply) begin
            kind = hopp_pkg::HOPP_INIT_OTHER;
        end else begin
            kind = hopp_pkg::HOPP_INIT_NONE;
        end
    end
endmodule
`default_nettype wire

//--- hopp_scale_calc.sv
`default_nettype none
// ----------------------------------------
// absolute scale arithmetic
// ----------------------------------------
module hopp_scale_calc #(
    parameter int GEAR_W = hopp_pkg::GEAR_W
) (
    input wire logic [23:0] scale_high,
    input wire logic [23:0] scale_low,
    input wire logic [23:0] offset_high,
    input wire logic [23:0] offset_low,
    input wire logic [GEAR_W-1:0] gear_reverse,
    input wire logic reversed,
    output logic [31:0] internal_value,
    output logic [31:0] scaled_value,
    output logic overflow
);
    logic [48:0] sum;
    logic [48+GEAR_W:0] prod;
    logic [32:0] neg;

    // offset-corrected sum is modular over 48 bits, offsets being negated halves
    always_comb begin
        sum = {1'b0, scale_high, scale_low} + {1'b0, offset_high, offset_low};
        internal_value = sum[31:0];
        // carry out of bit 47 is dropped: it would read as a huge value and trip falsely
        prod = {{(GEAR_W+1){sum[47]}}, sum[47:0]} * {{49{1'b0}}, gear_reverse};
        // sign extension matches signed product on the kept bits
        if (reversed) begin
            neg = 33'(-$signed(prod[32:0]));
        end else begin
            neg = prod[32:0];
        end
        scaled_value = neg[31:0];
        // anything beyond signed 32 bits, in the product or negation, is overflow
        overflow = (prod[48+GEAR_W:31] != {(GEAR_W+18){prod[31]}})
                 || (reversed && prod[31:0] == 32'h8000_0000);
    end
endmodule
`default_nettype wire

//--- hopp_master_model.sv
`default_nettype none
// ----------------------------------------
// fieldbus master: object writes, trigger pulses
// ----------------------------------------
module hopp_master_model (
    input wire logic ref_clk,
    output logic home_offset_wr,
    output logic [31:0] home_offset_wdata,
    output hopp_pkg::hopp_trig_t trig
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle until the bench asks for a process-data cycle
    initial begin
        home_offset_wr = 1'b0;
        home_offset_wdata = 32'h0000_0000;
        trig = '0;
    end
    // write and trigger may share one cycle; data is scrambled once released
    task automatic send(input logic wr, input logic [31:0] d, input logic [6:0] t);
        @(negedge ref_clk);
        home_offset_wr = wr;
        home_offset_wdata = d;
        trig = t;
        @(negedge ref_clk);
        home_offset_wr = 1'b0;
        trig = '0;
        home_offset_wdata = ~d;
    endtask
endmodule
`default_nettype wire

//--- hopp_top_properties.sv
`default_nettype none
// ----------------------------------------
// preset timing checks
// ----------------------------------------
module hopp_top_properties (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic home_offset_wr,
    input wire logic [31:0] home_offset_wdata,
    input wire logic [31:0] home_offset_rdata,
    input wire hopp_pkg::hopp_trig_t trig,
    input wire logic home_detected,
    input wire logic [23:0] scale_high,
    input wire logic [23:0] scale_low,
    input wire hopp_pkg::hopp_pos_t pos,
    input wire logic [23:0] abs_scale_offset_high,
    input wire logic [23:0] abs_scale_offset_low,
    input wire logic counter_overflow_trip
);
    // single domain, so one clocking and one reset guard
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    chk_wr_readback: assert property (
        home_offset_wr |=> home_offset_rdata == $past(home_offset_wdata))
        else $error("offset readback wrong");
    chk_offset_hold: assert property (
        !home_offset_wr |=> $stable(home_offset_rdata)) else $error("offset moved");
    chk_home_zero: assert property (
        trig.homing_done && home_detected |=> pos.internal_actual_position == 32'h0
        && pos.internal_demand_position == 32'h0) else $error("home not zeroed");
    chk_home_user: assert property (
        trig.homing_done && home_detected && !home_offset_wr |=>
        pos.user_actual_position == $past(home_offset_rdata)
        && pos.user_demand_position == $past(home_offset_rdata)) else $error("home user");
    chk_preset_equal: assert property (
        trig != 7'h00 && !trig.homing_done && !home_detected |=>
        pos.internal_demand_position == pos.internal_actual_position
        && pos.user_demand_position == pos.user_actual_position) else $error("preset mix");
    chk_scale_load_high: assert property (
        trig.homing_done && home_detected |=> abs_scale_offset_high == -$past(scale_high))
        else $error("offset high load");
    chk_scale_load_low: assert property (
        trig.homing_done && home_detected |=> abs_scale_offset_low == -$past(scale_low))
        else $error("offset low load");
    chk_trip_cause: assert property (
        $fell(counter_overflow_trip) |-> $past(trig) != 7'h00)
        else $error("trip cleared without trigger");
endmodule
bind hopp_top hopp_top_properties u_hopp_top_properties (.ref_clk(ref_clk), .srst(srst),
    .home_offset_wr(home_offset_wr), .home_offset_wdata(home_offset_wdata),
    .home_offset_rdata(home_offset_rdata), .trig(trig), .home_detected(home_detected),
    .scale_high(scale_high), .scale_low(scale_low), .pos(pos),
    .abs_scale_offset_high(abs_scale_offset_high),
    .abs_scale_offset_low(abs_scale_offset_low),
    .counter_overflow_trip(counter_overflow_trip));
`default_nettype wire

//--- hopp_top_bench.sv
`default_nettype none
// ----------------------------------------
// bench with scale-formula model
// ----------------------------------------
module hopp_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic home_offset_wr;
    logic [31:0] home_offset_wdata;
    logic [31:0] home_offset_rdata;
    hopp_pkg::hopp_trig_t trig;
    hopp_pkg::hopp_pos_t pos;
    logic home_detected = 1'b0;
    logic [7:0] direction_polarity = 8'h00;
    logic [hopp_pkg::GEAR_W-1:0] gear_reverse = 16'h0001;
    logic [23:0] scale_high = 24'h000010;
    logic [23:0] scale_low = 24'h000000;
    logic [31:0] encoder_position = 32'h0000_0000;
    logic full_closed = 1'b1;
    logic absolute_system = 1'b1;
    logic new_behaviour = 1'b1;
    logic [23:0] abs_scale_offset_high;
    logic [23:0] abs_scale_offset_low;
    logic counter_overflow_trip;
    logic [23:0] m_oh = 24'h000000;
    logic [23:0] m_ol = 24'h000000;
    logic [31:0] m_off = 32'h0000_0000;
    logic [31:0] m_reg = 32'h0000_0000;
    int errors = 0;
    int cmp_count = 0;
    int seed = 32'h1C45;
    hopp_top u_hopp_top (.ref_clk(ref_clk), .srst(srst), .home_offset_wr(home_offset_wr),
        .home_offset_wdata(home_offset_wdata), .home_offset_rdata(home_offset_rdata),
        .trig(trig), .home_detected(home_detected), .full_closed(full_closed),
        .absolute_system(absolute_system), .new_behaviour(new_behaviour),
        .direction_polarity(direction_polarity), .gear_reverse(gear_reverse),
        .scale_high(scale_high), .scale_low(scale_low), .encoder_position(encoder_position),
        .demand_step(32'h0000_0000), .pos(pos), .abs_scale_offset_high(abs_scale_offset_high),
        .abs_scale_offset_low(abs_scale_offset_low),
        .counter_overflow_trip(counter_overflow_trip));
    hopp_master_model u_hopp_master_model (.ref_clk(ref_clk), .home_offset_wr(home_offset_wr),
        .home_offset_wdata(home_offset_wdata), .trig(trig));
    // 50 ns period
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // homing keeps scale_low at zero so the negated halves cancel exactly
    task automatic expect_pos();
        longint s;
        logic [31:0] sc;
        s = ((longint'(scale_high) + m_oh) << 24) + scale_low + m_ol;
        sc = 32'(s * gear_reverse);
        if (direction_polarity == hopp_pkg::POLARITY_REVERSED) begin
            sc = -sc;
        end
        check(pos.internal_actual_position, s[31:0]);
        check(pos.internal_demand_position, s[31:0]);
        check(pos.user_actual_position, sc + m_off);
        check(pos.user_demand_position, sc + m_off);
        check({8'h00, abs_scale_offset_high}, {8'h00, m_oh});
        check({8'h00, abs_scale_offset_low}, {8'h00, m_ol});
    endtask
    // odd passes write first, so the trigger must pick up the stored value
    task automatic step(input logic [6:0] t, input bit wr_first);
        logic [31:0] d;
        d = $random(seed);
        if (wr_first) begin
            u_hopp_master_model.send(1'b1, d, 7'h00);
            m_reg = d;
            @(negedge ref_clk);
            check(home_offset_rdata, m_reg);
            expect_pos();
        end
        home_detected = t[4];
        scale_high = t[4] ? 24'h000010 : 24'h000010 + 24'($random(seed) & 3);
        scale_low = t[4] ? 24'h000000 : 24'($random(seed));
        gear_reverse = 16'($unsigned($random(seed)) % 3 + 1);
        direction_polarity = ($random(seed) & 1) ? hopp_pkg::POLARITY_REVERSED : 8'h00;
        u_hopp_master_model.send(!wr_first, d, t);
        m_reg = d;
        m_off = d;
        if (t[4]) begin
            m_oh = -scale_high;
            m_ol = -scale_low;
        end
        @(negedge ref_clk);
        expect_pos();
        check({31'h0, counter_overflow_trip}, 32'h0);
    endtask
    // encoder path: zero is the homed spot, or the encoder zero in old absolute mode
    task automatic enc_case(input bit abs_old);
        logic [31:0] z;
        logic [31:0] a;
        z = $random(seed);
        a = $random(seed);
        full_closed = 1'b0;
        absolute_system = abs_old;
        new_behaviour = !abs_old;
        direction_polarity = ($random(seed) & 1) ? hopp_pkg::POLARITY_REVERSED : 8'h00;
        encoder_position = z;
        home_detected = 1'b1;
        u_hopp_master_model.send(1'b0, 32'h0000_0000, 7'h10);
        m_oh = -scale_high;
        m_ol = -scale_low;
        @(negedge ref_clk);
        check(pos.internal_actual_position, 32'h0000_0000);
        check(pos.user_actual_position, m_reg);
        home_detected = 1'b0;
        encoder_position = z + a;
        u_hopp_master_model.send(1'b0, 32'h0000_0000, 7'h20);
        @(negedge ref_clk);
        if (abs_old) begin
            a = z + a;
        end
        check(pos.internal_demand_position, a);
        check(pos.internal_actual_position, a);
        if (direction_polarity == hopp_pkg::POLARITY_REVERSED) begin
            a = 32'h0000_0000 - a;
        end
        check(pos.user_actual_position, a + m_reg);
        check(pos.user_demand_position, a + m_reg);
        full_closed = 1'b1;
        absolute_system = 1'b1;
        new_behaviour = 1'b1;
    endtask
    // main sequence: power-up preset, every trigger, then overflow and recovery
    initial begin
        repeat (16) @(negedge ref_clk);
        srst = 1'b0;
        repeat (2) @(negedge ref_clk);
        expect_pos();
        enc_case(1'b0);
        enc_case(1'b1);
        for (int i = 0; i < 42; i++) begin
            step(7'h40 >> (i % 7), i[0]);
        end
        scale_high = 24'h000050;
        scale_low = 24'h000000;
        gear_reverse = 16'h0002;
        direction_polarity = 8'h00;
        home_detected = 1'b0;
        u_hopp_master_model.send(1'b0, 32'h0000_0000, 7'h04);
        @(negedge ref_clk);
        check({31'h0, counter_overflow_trip}, 32'h1);
        step(7'h01, 1'b0);
        final_report();
    end
    // watchdog: the run needs about 225 cycles
    initial begin
        #(5000 * 50);
        errors++;
        final_report();
    end
endmodule
`default_nettype wire
